//--- ctrf_accept_check.sv
// request acceptance decision against the upper filter mask
`default_nettype none
module ctrf_accept_check
   import ctrf_pkg::*;
(
   input wire logic [31:0] mask,
   input wire logic [9:0] local_bus,
   input wire ctrf_src_id_t src,
   output logic in_range,
   output logic accept
);
   logic [5:0] idx;
   logic is_local;

   assign is_local = (src.bus == local_bus) || (src.bus == CTRF_LOCAL_BUS);
   assign in_range = !is_local || (src.node >= CTRF_NODE_BASE && src.node <= CTRF_NODE_TOP);
   assign idx = src.node - CTRF_NODE_BASE;

   always_comb begin
      if (!is_local) begin
         accept = mask[CTRF_ALL_BUS_BIT];
      end else if (in_range) begin
         accept = mask[idx[4:0]];
      end else begin
         accept = 1'b0;
      end
   end
endmodule : ctrf_accept_check
`default_nettype wire

//--- ctrf_cycle_timer.sv
// cycle timer: three cascaded counters with load paths
`default_nettype none
module ctrf_cycle_timer
   import ctrf_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic run,
   input wire logic ext_tick,
   input wire logic ext_mode,
   input wire logic load_rx,
   input wire logic [31:0] rx_value,
   input wire logic load_sw,
   input wire logic [31:0] sw_value,
   output ctrf_time_t time_q
);
   ctrf_time_t time_ff;
   ctrf_time_t nxt_time;
   logic tick_wrap;
   logic cyc_wrap;

   assign time_q = time_ff;

   always_comb begin
      nxt_time = time_ff;
      tick_wrap = 1'b0;
      cyc_wrap = 1'b0;
      if (load_sw) begin
         nxt_time = ctrf_time_t'(sw_value);
      end else if (load_rx) begin
         nxt_time = ctrf_time_t'(rx_value);
      end else if (run) begin
         if (ext_mode) begin
            tick_wrap = ext_tick;
            if (ext_tick) begin
               nxt_time.timer_subcycle_ticks = 12'h000;
            end else if (time_ff.timer_subcycle_ticks != CTRF_TICK_MAX) begin
               nxt_time.timer_subcycle_ticks = time_ff.timer_subcycle_ticks + 12'h001;
            end
         end else begin
            tick_wrap = (time_ff.timer_subcycle_ticks == CTRF_TICK_MAX);
            nxt_time.timer_subcycle_ticks = tick_wrap ? 12'h000 :
               time_ff.timer_subcycle_ticks + 12'h001;
         end
         if (tick_wrap) begin
            cyc_wrap = (time_ff.timer_cycle_index == CTRF_CYC_MAX);
            nxt_time.timer_cycle_index = cyc_wrap ? 13'h0000 :
               time_ff.timer_cycle_index + 13'h0001;
         end
         if (cyc_wrap) begin
            nxt_time.timer_second_field = time_ff.timer_second_field + 7'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         time_ff <= ctrf_time_t'(CTRF_TIMER_RESET);
      end else if (ce) begin
         time_ff <= nxt_time;
      end
   end
endmodule : ctrf_cycle_timer
`default_nettype wire

//--- ctrf_node_model.sv
// partner: remote node sending asynchronous requests
`default_nettype none
module ctrf_node_model
   import ctrf_pkg::*;
(
   // ==========
   // request lines
   input wire logic clk_in,
   output logic valid_out,
   output ctrf_dest_t dest_out,
   output ctrf_src_id_t src_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      valid_out = 1'h0;
      dest_out = CTRF_DEST_OTHER;
      src_out = 16'h0;
   end
   task automatic send(input ctrf_src_id_t s, input ctrf_dest_t d);
      @(posedge clk_in);
      valid_out <= 1'h1;
      dest_out <= d;
      src_out <= s;
      @(posedge clk_in);
      valid_out <= 1'h0;
      // idle id lines must not look like the last sender
      src_out <= ~s;
   endtask : send
endmodule : ctrf_node_model
`default_nettype wire

//--- ctrf_pkg.sv
// package: register map, timer field layout and shared types
`default_nettype none
package ctrf_pkg;
   // ==========================================================
   // register offsets
   localparam logic [11:0] CTRF_OFS_CYCLE_TIME = 12'h0f0;
   localparam logic [11:0] CTRF_OFS_ACCEPT_SET = 12'h100;
   localparam logic [11:0] CTRF_OFS_ACCEPT_CLR = 12'h104;
   // ==========================================================
   // timer field layout and moduli
   localparam int CTRF_SEC_LSB = 25;
   localparam int CTRF_CYC_LSB = 12;
   localparam logic [6:0] CTRF_SEC_MAX = 7'h7f;
   localparam logic [12:0] CTRF_CYC_MAX = 13'h1f3f;
   localparam logic [11:0] CTRF_TICK_MAX = 12'hbff;
   // ==========================================================
   // filter layout
   localparam int CTRF_ALL_BUS_BIT = 31;
   localparam logic [5:0] CTRF_NODE_BASE = 6'h20;
   localparam logic [5:0] CTRF_NODE_TOP = 6'h3e;
   localparam logic [9:0] CTRF_LOCAL_BUS = 10'h3ff;
   localparam logic [31:0] CTRF_FILTER_RESET = 32'h0000_0000;
   localparam logic [31:0] CTRF_TIMER_RESET = 32'h0000_0000;
   // ==========================================================
   // types
   typedef struct packed {
      logic [6:0] timer_second_field;
      logic [12:0] timer_cycle_index;
      logic [11:0] timer_subcycle_ticks;
   } ctrf_time_t;
   typedef struct packed {
      logic [9:0] bus;
      logic [5:0] node;
   } ctrf_src_id_t;
   typedef enum logic [1:0] {
      CTRF_DEST_OTHER = 2'b00,
      CTRF_DEST_PHYS = 2'b01,
      CTRF_DEST_ASYNC_RECEIVE_REQUEST_QUEUE = 2'b10
   } ctrf_dest_t;
endpackage : ctrf_pkg
`default_nettype wire

//--- ctrf_tb.sv
// testbench: cycle timer and upper request filter
`default_nettype none
module tb
   import ctrf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'h0, rst_n = 1'h0, ce = 1'h1, wr_s = 1'h0, rd_s = 1'h0, mst = 1'h0, run = 1'h0, xm = 1'h0;
   logic xt = 1'h0, rx = 1'h0, txr = 1'h0, v, done, ack, que, rd_p = 1'h0, tx_p = 1'h0, rq_p = 1'h0;
   logic [11:0] addr = 12'h0;
   logic [31:0] wd = 32'h0, rxd = 32'h0, rdat, txd, r, m, seed = 32'h28c4;
   logic [9:0] lb = 10'h155;
   ctrf_dest_t dst;
   ctrf_src_id_t src;
   logic [31:0] q[$];
   int n_mismatch = 0, samples_checked = 0, cyc = 0;
   ctrf_top ctrf_top_i (.CLK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(ce), .REG_WR_IN(wr_s), .REG_RD_IN(rd_s),
      .REG_ADDR_IN(addr), .REG_WDATA_IN(wd), .REG_RDATA_OUT(rdat), .CYCLE_MASTER_IN(mst), .TIMER_RUN_IN(run),
      .EXT_CLOCK_MODE_IN(xm), .EXT_TICK_IN(xt), .CYCLE_START_RX_IN(rx), .CYCLE_START_DATA_IN(rxd),
      .CYCLE_START_TX_REQ_IN(txr), .CYCLE_START_TX_DATA_OUT(txd), .LOCAL_BUS_IN(lb), .REQ_VALID_IN(v),
      .REQ_DEST_IN(dst), .REQ_SRC_IN(src), .REQ_DONE_OUT(done), .REQ_ACK_OUT(ack), .REQ_QUEUE_OUT(que));
   ctrf_node_model ctrf_node_model_i (.clk_in(clk), .valid_out(v), .dest_out(dst), .src_out(src));
   // ==========
   // checking
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want) begin
         n_mismatch++;
         $display("CHECK FAILED %0t got %h want %h", $time, seen, want);
      end
   endtask : chk
   task automatic complete_run;
      if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   function automatic logic [31:0] nxt(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : nxt
   initial forever #2 clk = ~clk;
   always @(posedge clk) begin
      rd_p <= rd_s;
      tx_p <= txr;
      rq_p <= v;
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_mismatch++;
         complete_run();
      end
   end
   // one result at a time: stimulus never overlaps reads, captures and requests
   always @(negedge clk) begin
      if (rd_p || tx_p || rq_p) begin
         chk(rd_p ? rdat : tx_p ? txd : {29'h0, done, ack, que}, q.pop_front());
      end
   end
   // ==========
   // drivers
   task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      wr_s <= 1'h1;
      addr <= a;
      wd <= d;
      @(posedge clk);
      wr_s <= 1'h0;
   endtask : reg_wr
   task automatic reg_rd(input logic [11:0] a, input logic [31:0] e);
      q.push_back(e);
      @(posedge clk);
      rd_s <= 1'h1;
      addr <= a;
      @(posedge clk);
      rd_s <= 1'h0;
   endtask : reg_rd
   task automatic req(input logic [9:0] b, input logic [5:0] n, input ctrf_dest_t d, input logic [31:0] e);
      q.push_back(e);
      ctrf_node_model_i.send({b, n}, d);
   endtask : req
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      seed = nxt(seed);
      r = seed;
      m = r & 32'h7fff_ff00;
      reg_rd(CTRF_OFS_ACCEPT_SET, 32'h0);
      reg_wr(CTRF_OFS_ACCEPT_SET, r);
      reg_rd(CTRF_OFS_ACCEPT_CLR, r);
      reg_wr(CTRF_OFS_ACCEPT_CLR, 32'h8000_00ff);
      reg_rd(CTRF_OFS_ACCEPT_SET, m);
      reg_rd(CTRF_OFS_ACCEPT_CLR, m);
      reg_wr(12'h108, 32'hffff_ffff);
      reg_wr(CTRF_OFS_ACCEPT_SET, 32'h0);
      reg_rd(CTRF_OFS_ACCEPT_CLR, m);
      reg_rd(12'h0f4, 32'h0);
      for (int k = 0; k < 31; k++) req(lb, 6'(32 + k), k[0] ? CTRF_DEST_PHYS : CTRF_DEST_ASYNC_RECEIVE_REQUEST_QUEUE, m[k] ? 32'h7 : 32'h4);
      req(10'h001, 6'h05, CTRF_DEST_ASYNC_RECEIVE_REQUEST_QUEUE, 32'h4);
      req(lb, 6'h1f, CTRF_DEST_ASYNC_RECEIVE_REQUEST_QUEUE, 32'h0);
      req(10'h3ff, 6'h3f, CTRF_DEST_PHYS, 32'h0);
      reg_wr(CTRF_OFS_ACCEPT_SET, 32'h8000_0000);
      req(10'h001, 6'h3f, CTRF_DEST_PHYS, 32'h7);
      req(10'h002, 6'h05, CTRF_DEST_OTHER, 32'h0);
      reg_wr(CTRF_OFS_CYCLE_TIME, 32'hfff3_fbff);
      reg_rd(CTRF_OFS_CYCLE_TIME, 32'hfff3_fbff);
      run <= 1'h1;
      repeat (2) @(posedge clk);
      run <= 1'h0;
      reg_rd(CTRF_OFS_CYCLE_TIME, 32'h1);
      rxd <= r & 32'hfe7f_f7ff;
      rx <= 1'h1;
      @(posedge clk);
      rx <= 1'h0;
      reg_rd(CTRF_OFS_CYCLE_TIME, r & 32'hfe7f_f7ff);
      mst <= 1'h1;
      rxd <= 32'h0;
      rx <= 1'h1;
      @(posedge clk);
      rx <= 1'h0;
      q.push_back(r & 32'hfe7f_f7ff);
      txr <= 1'h1;
      @(posedge clk);
      txr <= 1'h0;
      reg_rd(CTRF_OFS_CYCLE_TIME, r & 32'hfe7f_f7ff);
      mst <= 1'h0;
      reg_wr(CTRF_OFS_CYCLE_TIME, 32'h0000_5123);
      xm <= 1'h1;
      run <= 1'h1;
      xt <= 1'h1;
      @(posedge clk);
      run <= 1'h0;
      xt <= 1'h0;
      reg_rd(CTRF_OFS_CYCLE_TIME, 32'h0000_6000);
      // ext mode without ticks: tick field stops at its top value, no carry
      reg_wr(CTRF_OFS_CYCLE_TIME, 32'h0000_0bfe);
      run <= 1'h1;
      repeat (2) @(posedge clk);
      run <= 1'h0;
      reg_rd(CTRF_OFS_CYCLE_TIME, 32'h0000_0bff);
      // enable low: a clear of every bit must not land
      ce <= 1'h0;
      reg_wr(CTRF_OFS_ACCEPT_CLR, 32'hffff_ffff);
      ce <= 1'h1;
      reg_rd(CTRF_OFS_ACCEPT_SET, m | 32'h8000_0000);
      repeat (3) @(posedge clk);
      chk(32'(q.size()), 32'h0);
      complete_run();
   end
endmodule : tb
`default_nettype wire

//--- ctrf_top.sv
// cycle timer and upper asynchronous request filter, top level
//
// How it works
// - as cycle master, outgoing cycle start carries current timer value
// - otherwise each received cycle start loads the whole timer, unless a register write to it lands in the same cycle
// - without cycle starts the timer keeps counting when enabled
// - seconds field in bits 31..25 counts cycle rollovers modulo 128
// - cycle field in bits 24..12 counts tick rollovers modulo 8000
// - tick field in bits 11..0 counts clocks modulo 3072 outside external mode
// - in external 8 kHz mode each external tick clears the tick field
// - requests for physical or receive queue are checked by source node
// - filtered-out requests are neither acknowledged nor queued
// - per-node check applies only to sources on our own bus
// - remote-bus requests accepted only when bit 31 is set
// - bit k enables local node k plus 32, nodes 32 to 62
// - ones written at set address set bits, at clear address clear
`default_nettype none
module ctrf_top
   import ctrf_pkg::*;
(
   // clock, reset, enable
   input wire logic CLK_IN,
   input wire logic RESET_N_IN,
   input wire logic CE_IN,
   // register port
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   input wire logic [11:0] REG_ADDR_IN,
   input wire logic [31:0] REG_WDATA_IN,
   output logic [31:0] REG_RDATA_OUT,
   // cycle control
   input wire logic CYCLE_MASTER_IN,
   input wire logic TIMER_RUN_IN,
   input wire logic EXT_CLOCK_MODE_IN,
   input wire logic EXT_TICK_IN,
   input wire logic CYCLE_START_RX_IN,
   input wire logic [31:0] CYCLE_START_DATA_IN,
   input wire logic CYCLE_START_TX_REQ_IN,
   output logic [31:0] CYCLE_START_TX_DATA_OUT,
   // receive request check
   input wire logic [9:0] LOCAL_BUS_IN,
   input wire logic REQ_VALID_IN,
   input wire ctrf_dest_t REQ_DEST_IN,
   input wire ctrf_src_id_t REQ_SRC_IN,
   output logic REQ_DONE_OUT,
   output logic REQ_ACK_OUT,
   output logic REQ_QUEUE_OUT
);
   // ==========================================================
   // register decode
   logic [31:0] filter_ff;
   logic [31:0] nxt_filter;
   logic [31:0] tx_data_ff;
   logic [31:0] rdata_ff;
   logic done_ff;
   logic ack_ff;
   logic queue_ff;
   logic wr_time;
   logic wr_set;
   logic wr_clr;
   logic rx_load;
   logic accept;
   logic in_range;
   logic checked;
   ctrf_time_t time_q;

   assign wr_time = REG_WR_IN && (REG_ADDR_IN == CTRF_OFS_CYCLE_TIME);
   assign wr_set = REG_WR_IN && (REG_ADDR_IN == CTRF_OFS_ACCEPT_SET);
   assign wr_clr = REG_WR_IN && (REG_ADDR_IN == CTRF_OFS_ACCEPT_CLR);
   // cycle master ignores incoming starts: it is the time source
   assign rx_load = CYCLE_START_RX_IN && !CYCLE_MASTER_IN;

   // ==========================================================
   // cycle timer
   ctrf_cycle_timer u_timer (
      .clk(CLK_IN),
      .rst_n(RESET_N_IN),
      .ce(CE_IN),
      .run(TIMER_RUN_IN),
      .ext_tick(EXT_TICK_IN),
      .ext_mode(EXT_CLOCK_MODE_IN),
      .load_rx(rx_load),
      .rx_value(CYCLE_START_DATA_IN),
      .load_sw(wr_time),
      .sw_value(REG_WDATA_IN),
      .time_q(time_q)
   );

   // snapshot for the outgoing cycle start, taken only as master
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         tx_data_ff <= 32'h0000_0000;
      end else if (CE_IN && CYCLE_MASTER_IN && CYCLE_START_TX_REQ_IN) begin
         tx_data_ff <= time_q;
      end
   end
   assign CYCLE_START_TX_DATA_OUT = tx_data_ff;

   // ==========================================================
   // upper acceptance filter
   always_comb begin
      nxt_filter = filter_ff;
      if (wr_set) begin
         nxt_filter = filter_ff | REG_WDATA_IN;
      end else if (wr_clr) begin
         nxt_filter = filter_ff & ~REG_WDATA_IN;
      end
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         filter_ff <= CTRF_FILTER_RESET;
      end else if (CE_IN) begin
         filter_ff <= nxt_filter;
      end
   end

   // ==========================================================
   // register read, one cycle after the strobe
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         rdata_ff <= 32'h0000_0000;
      end else if (CE_IN && REG_RD_IN) begin
         unique case (REG_ADDR_IN)
            CTRF_OFS_CYCLE_TIME: rdata_ff <= time_q;
            CTRF_OFS_ACCEPT_SET, CTRF_OFS_ACCEPT_CLR: rdata_ff <= filter_ff;
            default: rdata_ff <= 32'h0000_0000;
         endcase
      end
   end
   assign REG_RDATA_OUT = rdata_ff;

   // ==========================================================
   // request check
   ctrf_accept_check u_check (
      .mask(filter_ff),
      .local_bus(LOCAL_BUS_IN),
      .src(REQ_SRC_IN),
      .in_range(in_range),
      .accept(accept)
   );

   // lower nodes belong to the other filter half: not decided here
   assign checked = REQ_VALID_IN && in_range &&
      (REQ_DEST_IN == CTRF_DEST_PHYS || REQ_DEST_IN == CTRF_DEST_ASYNC_RECEIVE_REQUEST_QUEUE);

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         done_ff <= 1'b0;
         ack_ff <= 1'b0;
         queue_ff <= 1'b0;
      end else if (CE_IN) begin
         done_ff <= checked;
         ack_ff <= checked && accept;
         queue_ff <= checked && accept;
      end
   end
   assign REQ_DONE_OUT = done_ff;
   assign REQ_ACK_OUT = ack_ff;
   assign REQ_QUEUE_OUT = queue_ff;
endmodule : ctrf_top
`default_nettype wire

//--- ctrf_top_props.sv
// checker: port relations of the cycle timer and request filter
`default_nettype none
module ctrf_top_props
   import ctrf_pkg::*;
(
   // clock, reset, enable
   input wire logic CLK_IN,
   input wire logic RESET_N_IN,
   input wire logic CE_IN,
   // register port
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   input wire logic [11:0] REG_ADDR_IN,
   input wire logic [31:0] REG_WDATA_IN,
   input wire logic [31:0] REG_RDATA_OUT,
   // cycle control
   input wire logic TIMER_RUN_IN,
   input wire logic CYCLE_START_TX_REQ_IN,
   input wire logic [31:0] CYCLE_START_TX_DATA_OUT,
   // receive request check
   input wire logic [9:0] LOCAL_BUS_IN,
   input wire logic REQ_VALID_IN,
   input wire ctrf_dest_t REQ_DEST_IN,
   input wire ctrf_src_id_t REQ_SRC_IN,
   input wire logic REQ_DONE_OUT,
   input wire logic REQ_ACK_OUT,
   input wire logic REQ_QUEUE_OUT
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RESET_N_IN);
   wire logic [11:0] a = REG_ADDR_IN;
   wire logic [31:0] wd = REG_WDATA_IN;
   wire logic [31:0] rq = REG_RDATA_OUT;
   wire logic rdx = CE_IN && REG_RD_IN && !REG_WR_IN;
   wire logic wrx = CE_IN && REG_WR_IN;
   wire logic go = CE_IN && REQ_VALID_IN && REQ_DEST_IN != CTRF_DEST_OTHER;
   // the all-ones bus number also names our own bus
   wire logic loc = REQ_SRC_IN.bus == LOCAL_BUS_IN || REQ_SRC_IN.bus == CTRF_LOCAL_BUS;
   wire logic rng = !loc || (REQ_SRC_IN.node >= CTRF_NODE_BASE && REQ_SRC_IN.node <= CTRF_NODE_TOP);
   // ==========
   // properties
   take_in_range_a: assert property (go && rng |=> REQ_DONE_OUT)
      else $error("in-range request not decided");
   out_of_range_a: assert property (go && !rng |=> !REQ_DONE_OUT && !REQ_ACK_OUT)
      else $error("out-of-range request decided");
   ack_with_queue_a: assert property (REQ_QUEUE_OUT == REQ_ACK_OUT && (!REQ_ACK_OUT || REQ_DONE_OUT))
      else $error("ack and queue disagree");
   set_reads_back_a: assert property (
      wrx && a == CTRF_OFS_ACCEPT_SET ##1 !REG_WR_IN ##1 rdx && a == CTRF_OFS_ACCEPT_CLR
      |=> (rq & $past(wd, 3)) == $past(wd, 3))
      else $error("set bits not visible");
   clear_reads_back_a: assert property (
      wrx && a == CTRF_OFS_ACCEPT_CLR ##1 !REG_WR_IN ##1 rdx && a == CTRF_OFS_ACCEPT_SET
      |=> (rq & $past(wd, 3)) == 32'h0)
      else $error("cleared bits still set");
   both_views_a: assert property (
      rdx && a == CTRF_OFS_ACCEPT_SET ##1 !REG_WR_IN ##1 rdx && a == CTRF_OFS_ACCEPT_CLR
      |=> rq == $past(rq, 2))
      else $error("set and clear views differ");
   timer_write_a: assert property (
      wrx && a == CTRF_OFS_CYCLE_TIME && !TIMER_RUN_IN ##1 !REG_WR_IN && !TIMER_RUN_IN
      ##1 rdx && a == CTRF_OFS_CYCLE_TIME && !TIMER_RUN_IN |=> rq == $past(wd, 3))
      else $error("timer write not read back");
   tx_holds_a: assert property (!(CE_IN && CYCLE_START_TX_REQ_IN) |=> $stable(CYCLE_START_TX_DATA_OUT))
      else $error("tx value moved without request");
endmodule : ctrf_top_props
bind ctrf_top ctrf_top_props ctrf_top_props_i (.*);
`default_nettype wire
